// >>> logic/nfc_target_defs.vh
// Constants for the active target sequencer
`ifndef NFC_TARGET_DEFS_VH
`define NFC_TARGET_DEFS_VH
// Clock rate in kHz
`define CLK_KHZ 125000
// Active response guard time in microseconds
`define ARFG_US 75
// Guard time in cycles, rounded up
`define ARFG_CYC (((`ARFG_US * `CLK_KHZ) + 999) / 1000)
// Sub-mode encodings
`define SUBMODE_DETECT 1'b0
`define SUBMODE_NORMAL 1'b1
// Bit rate codes
`define RATE_106 2'h0
`define RATE_212 2'h1
`define RATE_424 2'h2
// Protocol codes for the analog preset
`define PROTO_14443A 3'h0
`define PROTO_14443B 3'h1
`define PROTO_PROP 3'h2
`define PROTO_NFCIP 3'h3
// Reset values and timer width
`define RATE_RESET 2'h0
`define TIMER_W 24
`endif

// >>> logic/interval_timer.v
// Loadable down-counter that pulses once on expiry
`timescale 1ns/1ps
module interval_timer #(
  parameter W = 24
) (
  input wire clk_in,
  input wire resetn_in,
  input wire start_in,
  input wire stop_in,
  input wire [W-1:0] len_in,
  output reg busy_out,
  output reg done_out
);
  reg [W-1:0] cnt_q;
  // Count down while busy, pulse done at zero
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cnt_q <= {W{1'b0}};
      busy_out <= 1'b0;
      done_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      if (start_in) begin
        cnt_q <= len_in;
        busy_out <= 1'b1;
      end else if (stop_in) begin
        busy_out <= 1'b0;
      end else if (busy_out) begin
        if (cnt_q == {W{1'b0}}) begin
          busy_out <= 1'b0;
          done_out <= 1'b1;
        end else begin
          cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule // interval_timer

// >>> logic/nfc_active_target_sequencer.v
// Active target sequencer: field detect, rate detect, response loop
//
// Functional notes
// (R1) Target-select bit enters target operation
// (R2) Target select forces field detector enable
// (R3) All control zero gives low-power state
// (R4) Rate-detect or normal sub-mode with rate
// (R5) Host configures analog like initiator
// (R6) Host keeps repetition bits zero in loop
// (R7) Field-on in low power raises flag
// (R8) Receive watched only after mask timer
// (R9) Start-of-receive, then rate detected flag
// (R10) Auto response needs detected bit rate
// (R11) Received message ends with end flag
// (R12) Go-normal copies rate, sets normal mode
// (R13) Host sets modulation to match rate
// (R14) Field-off flag, then response field-on
// (R15) No collision: field on, guard, done flag
// (R16) Host sends reply after field-on flag
// (R17) Field off after general timer interval
// (R18) No-response timer, expiry flag
// (R19) Field-on restarts mask-receive timer
// (R20) Host clears control to return idle
// (R21) One bit selects OOK or AM
// (R22) Preset selects AM for listed protocols
`timescale 1ns/1ps
`include "nfc_target_defs.vh"
module nfc_active_target_sequencer #(
  parameter TW = `TIMER_W,
  parameter ARFG_CYCLES = `ARFG_CYC
) (
  input wire clk_in,
  input wire resetn_in,
  input wire target_select_in,
  input wire submode_wr_in,
  input wire submode_in,
  input wire auto_response_coll_avoid_in,
  input wire [7:0] op_control_in,
  input wire resp_ca_count_hi_in,
  input wire resp_ca_count_lo_in,
  input wire am_wr_in,
  input wire am_modulation_select_in,
  input wire preset_in,
  input wire [2:0] protocol_in,
  input wire [1:0] cfg_rate_in,
  input wire rate_wr_in,
  input wire [1:0] rate_wdata_in,
  input wire cmd_mask_rx_in,
  input wire cmd_go_normal_in,
  input wire cmd_transmit_in,
  input wire [TW-1:0] mask_rx_len_in,
  input wire [TW-1:0] gpt_len_in,
  input wire [TW-1:0] nrt_len_in,
  input wire ext_field_in,
  input wire collision_in,
  input wire rx_start_in,
  input wire rx_end_in,
  input wire rate_ok_in,
  input wire [1:0] rate_meas_in,
  input wire tx_done_in,
  output reg ext_field_detector_enable_out,
  output reg low_power_out,
  output reg submode_out,
  output reg [1:0] rate_def_out,
  output reg [1:0] rate_disp_out,
  output reg rx_watch_out,
  output reg rate_detect_run_out,
  output reg field_on_out,
  output reg tx_go_out,
  output reg am_modulation_select_out,
  output reg irq_eon_out,
  output reg irq_eof_out,
  output reg irq_sor_out,
  output reg irq_nfct_out,
  output reg irq_eor_out,
  output reg irq_cat_out,
  output reg irq_gpt_out,
  output reg irq_nrt_out
);
  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam S_IDLE = 8'h01;
  localparam S_MASK = 8'h02;
  localparam S_RX = 8'h04;
  localparam S_WOFF = 8'h08;
  localparam S_CA = 8'h10;
  localparam S_GUARD = 8'h20;
  localparam S_TX = 8'h40;
  localparam S_NRT = 8'h80;

  reg [7:0] state_q, state_d;
  reg field_s1_q, field_s2_q, field_s3_q;
  reg coll_s1_q, coll_s2_q;
  reg rxs_s1_q, rxs_s2_q;
  reg rxe_s1_q, rxe_s2_q;
  reg rok_s1_q, rok_s2_q;
  reg txd_s1_q, txd_s2_q;
  reg rate_seen_q;
  reg [TW-1:0] guard_q;
  reg [1:0] ca_left_q;
  wire field_rise, field_fall, active, low_power_d;
  wire mask_busy, mask_done, gpt_done, nrt_done;
  wire mask_start, gpt_start, nrt_start, nrt_stop;

  // ----------------------------------------------------------------
  // Synchronisers for pin-side inputs
  // ----------------------------------------------------------------
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      field_s1_q <= 1'b0;
      field_s2_q <= 1'b0;
      field_s3_q <= 1'b0;
      coll_s1_q <= 1'b0;
      coll_s2_q <= 1'b0;
      rxs_s1_q <= 1'b0;
      rxs_s2_q <= 1'b0;
      rxe_s1_q <= 1'b0;
      rxe_s2_q <= 1'b0;
      rok_s1_q <= 1'b0;
      rok_s2_q <= 1'b0;
      txd_s1_q <= 1'b0;
      txd_s2_q <= 1'b0;
    end else begin
      field_s1_q <= ext_field_in;
      field_s2_q <= field_s1_q;
      field_s3_q <= field_s2_q;
      coll_s1_q <= collision_in;
      coll_s2_q <= coll_s1_q;
      rxs_s1_q <= rx_start_in;
      rxs_s2_q <= rxs_s1_q;
      rxe_s1_q <= rx_end_in;
      rxe_s2_q <= rxe_s1_q;
      rok_s1_q <= rate_ok_in;
      rok_s2_q <= rok_s1_q;
      txd_s1_q <= tx_done_in;
      txd_s2_q <= txd_s1_q;
    end
  end

  // Field edges seen by the detector
  assign field_rise = field_s2_q & ~field_s3_q;
  assign field_fall = ~field_s2_q & field_s3_q;
  // (R1) target operation entry
  assign active = target_select_in;
  // (R3) low-power initial target state
  assign low_power_d = target_select_in & (op_control_in == 8'h00);

  // ----------------------------------------------------------------
  // Timers
  // ----------------------------------------------------------------
  // (R8) (R19) mask-receive timer starts
  assign mask_start = (cmd_mask_rx_in & active) | ((state_q == S_NRT) & field_rise);
  // (R17) general timer starts at end of reply
  assign gpt_start = (state_q == S_TX) & txd_s2_q;
  // (R18) no-response timer after field off
  assign nrt_start = (state_q == S_TX) & gpt_done;
  assign nrt_stop = ~active | field_rise;

  interval_timer #(.W(TW)) u_mask (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .start_in(mask_start),
    .stop_in(~active),
    .len_in(mask_rx_len_in),
    .busy_out(mask_busy),
    .done_out(mask_done)
  );
  interval_timer #(.W(TW)) u_gpt (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .start_in(gpt_start),
    .stop_in(~active),
    .len_in(gpt_len_in),
    .busy_out(),
    .done_out(gpt_done)
  );
  interval_timer #(.W(TW)) u_nrt (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .start_in(nrt_start),
    .stop_in(nrt_stop),
    .len_in(nrt_len_in),
    .busy_out(),
    .done_out(nrt_done)
  );

  // ----------------------------------------------------------------
  // Sequence state machine
  // ----------------------------------------------------------------
  always @* begin
    state_d = state_q;
    case (state_q)
      S_IDLE: begin
        if (active & field_rise) begin
          state_d = S_MASK;
        end
      end
      S_MASK: begin
        // (R14) field lost before receive still leads to the field-off flag and the response check
        if (field_fall) begin
          state_d = S_WOFF;
        end else if (mask_done) begin
          state_d = S_RX;
        end
      end
      S_RX: begin
        if (field_fall) begin
          state_d = S_WOFF;
        end
      end
      S_WOFF: begin
        // (R10) response only with a detected rate or in normal sub-mode
        if (auto_response_coll_avoid_in & rate_seen_q) begin
          state_d = S_CA;
        end else begin
          state_d = S_IDLE;
        end
      end
      S_CA: begin
        // (R15) own field on when no collision
        if (coll_s2_q) begin
          state_d = S_IDLE;
        end else if (ca_left_q == 2'h0) begin
          state_d = S_GUARD;
        end
      end
      S_GUARD: begin
        if (guard_q == {TW{1'b0}}) begin
          state_d = S_TX;
        end
      end
      S_TX: begin
        if (gpt_done) begin
          state_d = S_NRT;
        end
      end
      S_NRT: begin
        if (field_rise) begin
          state_d = S_MASK;
        end else if (nrt_done) begin
          state_d = S_IDLE;
        end
      end
      default: begin
        state_d = S_IDLE;
      end
    endcase
    if (!active) begin
      state_d = S_IDLE;
    end
  end

  // ----------------------------------------------------------------
  // Registered state, counters and outputs
  // ----------------------------------------------------------------
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_q <= S_IDLE;
      guard_q <= {TW{1'b0}};
      ca_left_q <= 2'h0;
      rate_seen_q <= 1'b0;
      ext_field_detector_enable_out <= 1'b0;
      low_power_out <= 1'b0;
      submode_out <= `SUBMODE_DETECT;
      rate_def_out <= `RATE_RESET;
      rate_disp_out <= `RATE_RESET;
      rx_watch_out <= 1'b0;
      rate_detect_run_out <= 1'b0;
      field_on_out <= 1'b0;
      tx_go_out <= 1'b0;
      am_modulation_select_out <= 1'b0;
      irq_eon_out <= 1'b0;
      irq_eof_out <= 1'b0;
      irq_sor_out <= 1'b0;
      irq_nfct_out <= 1'b0;
      irq_eor_out <= 1'b0;
      irq_cat_out <= 1'b0;
      irq_gpt_out <= 1'b0;
      irq_nrt_out <= 1'b0;
    end else begin
      state_q <= state_d;
      // (R2) detector enabled with target select
      ext_field_detector_enable_out <= target_select_in;
      low_power_out <= low_power_d;
      // (R7) (R19) field-on event flag
      irq_eon_out <= active & field_rise & ((state_q == S_IDLE) | (state_q == S_NRT));
      // (R14) field-off event flag
      irq_eof_out <= ((state_q == S_MASK) | (state_q == S_RX)) & field_fall;
      // (R8) receiver watched after mask expiry
      rx_watch_out <= (state_q == S_RX);
      // (R9) start of receive and rate recognition
      irq_sor_out <= (state_q == S_RX) & rxs_s2_q;
      if ((state_q == S_RX) & rxs_s2_q & (submode_out == `SUBMODE_DETECT)) begin
        rate_detect_run_out <= 1'b1;
      end else if (rate_detect_run_out & rok_s2_q) begin
        rate_detect_run_out <= 1'b0;
      end else if (!active) begin
        rate_detect_run_out <= 1'b0;
      end
      irq_nfct_out <= rate_detect_run_out & rok_s2_q;
      if (rate_detect_run_out & rok_s2_q) begin
        rate_disp_out <= rate_meas_in;
        rate_seen_q <= 1'b1;
      end else if (!active) begin
        rate_seen_q <= 1'b0;
      end
      // (R11) end-of-receive flag
      irq_eor_out <= (state_q == S_RX) & rxe_s2_q;
      // (R4) (R12) sub-mode and rate definition
      if (cmd_go_normal_in & active) begin
        rate_def_out <= rate_disp_out;
        submode_out <= `SUBMODE_NORMAL;
      end else begin
        if (rate_wr_in) begin
          rate_def_out <= rate_wdata_in;
        end
        if (submode_wr_in) begin
          submode_out <= submode_in;
        end
      end
      if (submode_out == `SUBMODE_NORMAL) begin
        rate_seen_q <= 1'b1;
      end
      // (R14) repetition count from the two bits
      if (state_q == S_WOFF) begin
        ca_left_q <= {resp_ca_count_hi_in, resp_ca_count_lo_in};
      end else if ((state_q == S_CA) & (ca_left_q != 2'h0)) begin
        ca_left_q <= ca_left_q - 2'h1;
      end
      // (R15) guard time then done flag
      if (state_d == S_GUARD && state_q != S_GUARD) begin
        guard_q <= ARFG_CYCLES[TW-1:0];
      end else if ((state_q == S_GUARD) & (guard_q != {TW{1'b0}})) begin
        guard_q <= guard_q - {{(TW-1){1'b0}}, 1'b1};
      end
      irq_cat_out <= (state_q == S_GUARD) & (guard_q == {TW{1'b0}});
      // (R15) (R17) own field drive
      field_on_out <= (state_d == S_GUARD) | (state_d == S_TX);
      tx_go_out <= (state_q == S_TX) & cmd_transmit_in;
      irq_gpt_out <= gpt_done;
      // (R18) no-response expiry flag
      irq_nrt_out <= nrt_done & (state_q == S_NRT);
      // (R21) (R22) modulation select
      if (preset_in) begin
        am_modulation_select_out <= (protocol_in == `PROTO_14443B) |
          (protocol_in == `PROTO_PROP) |
          ((protocol_in == `PROTO_NFCIP) &
           ((cfg_rate_in == `RATE_212) | (cfg_rate_in == `RATE_424)));
      end else if (am_wr_in) begin
        am_modulation_select_out <= am_modulation_select_in;
      end
    end
  end
endmodule // nfc_active_target_sequencer

// >>> verif/nfc_target_asserts.sv
// Port-level checks for the active target sequencer
`timescale 1ns/1ps
module nfc_target_asserts #(
  parameter TW = 24,
  parameter ARFG_CYCLES = 20
) (
  input wire clk_in,
  input wire resetn_in,
  input wire target_select_in,
  input wire [7:0] op_control_in,
  input wire am_wr_in,
  input wire am_modulation_select_in,
  input wire preset_in,
  input wire [2:0] protocol_in,
  input wire [1:0] cfg_rate_in,
  input wire cmd_go_normal_in,
  input wire ext_field_detector_enable_out,
  input wire low_power_out,
  input wire submode_out,
  input wire [1:0] rate_def_out,
  input wire [1:0] rate_disp_out,
  input wire rx_watch_out,
  input wire field_on_out,
  input wire am_modulation_select_out,
  input wire irq_eon_out,
  input wire irq_cat_out
);
  // ----
  // Checks
  // ----
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  chk_fd_enable: assert property (target_select_in [*3] |-> ext_field_detector_enable_out)
    else $error("detector not enabled");
  chk_low_power: assert property (
    (target_select_in && op_control_in == 8'h00) [*3] |-> low_power_out)
    else $error("low power state missing");
  chk_go_normal: assert property (cmd_go_normal_in && target_select_in |=>
    submode_out && rate_def_out == $past(rate_disp_out)) else $error("go normal copy wrong");
  chk_am_write: assert property (am_wr_in && !preset_in |=>
    am_modulation_select_out == $past(am_modulation_select_in)) else $error("am write lost");
  chk_am_preset: assert property (preset_in |=> am_modulation_select_out ==
    ($past(protocol_in) == 3'h1 || $past(protocol_in) == 3'h2 ||
    ($past(protocol_in) == 3'h3 &&
    ($past(cfg_rate_in) == 2'h1 || $past(cfg_rate_in) == 2'h2))))
    else $error("preset modulation wrong");
  chk_cat_field: assert property (irq_cat_out |-> field_on_out)
    else $error("guard done without field");
  chk_rx_field: assert property (rx_watch_out |-> !field_on_out)
    else $error("receiving with own field on");
  chk_idle_quiet: assert property (!target_select_in [*3] |-> !field_on_out && !irq_eon_out)
    else $error("activity outside target operation");
endmodule // nfc_target_asserts

// >>> verif/initiator_model.sv
// Behavioural remote initiator: field level and receive-side events
`timescale 1ns/1ps
module initiator_model (
  input wire clk_in,
  output reg field_out,
  output reg rx_start_out,
  output reg rx_end_out,
  output reg rate_ok_out,
  output reg [1:0] rate_meas_out,
  output reg tx_done_out
);
  initial begin
    {field_out, rx_start_out, rx_end_out, rate_ok_out, tx_done_out} = 5'h00;
    rate_meas_out = 2'h3;
  end
  // Field switched between clock edges
  task field(input logic v);
    @(negedge clk_in);
    field_out = v;
  endtask
  // One-cycle event: k 0 start, 1 end, 2 rate found, 3 reply sent
  task automatic ev(input int k, input logic [1:0] r);
    @(negedge clk_in);
    if (k == 2) rate_meas_out = r;
    {rx_start_out, rx_end_out, rate_ok_out, tx_done_out} = 4'h8 >> k;
    @(negedge clk_in);
    {rx_start_out, rx_end_out, rate_ok_out, tx_done_out} = 4'h0;
    // Measured rate only valid briefly, then scrambled
    if (k == 2) fork
      begin
        repeat (6) @(negedge clk_in);
        rate_meas_out = ~r;
      end
    join_none
  endtask
endmodule // initiator_model

// >>> verif/nfc_active_target_sequencer_tb.sv
// Self-checking bench for the active target sequencer
`timescale 1ns/1ps
module nfc_active_target_sequencer_tb;
  logic clk_in = 0, resetn_in = 0, target_select_in = 0, submode_wr_in = 0, submode_in = 0;
  logic auto_response_coll_avoid_in = 0, am_wr_in = 0, am_modulation_select_in = 0;
  logic preset_in = 0, rate_wr_in = 0, cmd_mask_rx_in = 0, cmd_go_normal_in = 0;
  logic cmd_transmit_in = 0, collision_in = 0;
  logic resp_ca_count_hi_in = 0, resp_ca_count_lo_in = 0;
  logic [7:0] op_control_in = 8'h00;
  logic [2:0] protocol_in = 3'h0;
  logic [1:0] cfg_rate_in = 2'h0, rate_wdata_in = 2'h0;
  logic [23:0] mask_rx_len_in = 24'h000005, gpt_len_in = 24'h000004, nrt_len_in = 24'h0000c8;
  wire ext_field_in, rx_start_in, rx_end_in, rate_ok_in, tx_done_in;
  wire [1:0] rate_meas_in, rate_def_out, rate_disp_out;
  wire ext_field_detector_enable_out, low_power_out, submode_out, rx_watch_out;
  wire rate_detect_run_out, field_on_out, tx_go_out, am_modulation_select_out;
  wire irq_eon_out, irq_eof_out, irq_sor_out, irq_nfct_out, irq_eor_out;
  wire irq_cat_out, irq_gpt_out, irq_nrt_out;
  wire [9:0] ev = {irq_eon_out, irq_eof_out, irq_sor_out, irq_nfct_out, irq_eor_out,
    irq_cat_out, irq_gpt_out, irq_nrt_out, rx_watch_out, tx_go_out};
  int num_errors = 0, checks = 0;
  logic seen = 0;
  always #4 clk_in = ~clk_in;
  nfc_active_target_sequencer #(.ARFG_CYCLES(20)) dut (.*);
  initiator_model ini (.clk_in(clk_in), .field_out(ext_field_in), .rx_start_out(rx_start_in),
    .rx_end_out(rx_end_in), .rate_ok_out(rate_ok_in), .rate_meas_out(rate_meas_in),
    .tx_done_out(tx_done_in));
  // ----
  // Tasks
  // ----
  task chk(input string n, input logic [3:0] e, input logic [3:0] g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  // Bounded wait for one event bit
  task wt(input int b, input string n);
    int i;
    i = 0;
    while (ev[b] !== 1'b1 && i < 300) begin
      @(negedge clk_in);
      i++;
    end
    chk(n, 1, ev[b]);
  endtask
  // One-cycle command: 0 mask timer, 1 go normal, 2 transmit
  task cmd(input int k);
    @(negedge clk_in);
    {cmd_transmit_in, cmd_go_normal_in, cmd_mask_rx_in} = 3'h1 << k;
    @(negedge clk_in);
    {cmd_transmit_in, cmd_go_normal_in, cmd_mask_rx_in} = 3'h0;
  endtask
  task set_am(input logic v);
    am_modulation_select_in = v;
    am_wr_in = 1;
    @(negedge clk_in);
    am_wr_in = 0;
  endtask
  // Field drop, response guard, reply, field release
  task reply;
    ini.field(0);
    wt(8, "field off");
    wt(4, "guard done");
    chk("own field", 1, field_on_out);
    cmd(2);
    wt(0, "transmit");
    ini.ev(3, 2'h0);
    wt(3, "gp timer");
    repeat (2) @(negedge clk_in);
    chk("field released", 0, field_on_out);
  endtask
  task tally_and_finish;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // ----
  // Sequence
  // ----
  initial begin
    repeat (8) @(negedge clk_in);
    resetn_in = 1;
    repeat (3) @(negedge clk_in);
    target_select_in = 1;
    repeat (4) @(negedge clk_in);
    chk("detector enable", 1, ext_field_detector_enable_out);
    chk("low power", 1, low_power_out);
    set_am(1);
    chk("am write", 1, am_modulation_select_out);
    for (int p = 0; p < 4; p++)
      for (int r = 0; r < 3; r++) begin
        protocol_in = p[2:0];
        cfg_rate_in = r[1:0];
        preset_in = 1;
        @(negedge clk_in);
        preset_in = 0;
        chk("am preset", p == 1 || p == 2 || (p == 3 && r > 0), am_modulation_select_out);
        @(negedge clk_in);
      end
    rate_wdata_in = 2'h1;
    rate_wr_in = 1;
    @(negedge clk_in);
    rate_wr_in = 0;
    chk("rate definition", 1, rate_def_out);
    auto_response_coll_avoid_in = 1;
    // Field comes and goes before any rate is known
    ini.field(1);
    wt(9, "field on");
    ini.field(0);
    wt(8, "field off");
    repeat (60) @(negedge clk_in) seen |= irq_cat_out;
    chk("no guard without rate", 0, seen);
    ini.field(1);
    wt(9, "field on");
    op_control_in = 8'h01;
    cmd(0);
    wt(1, "receive watch");
    ini.ev(0, 2'h0);
    wt(7, "start of receive");
    chk("rate detect run", 1, rate_detect_run_out);
    ini.ev(2, 2'h2);
    wt(6, "rate detected");
    chk("rate display", 2, rate_disp_out);
    ini.ev(1, 2'h0);
    wt(5, "end of receive");
    cmd(1);
    chk("normal mode", 1, submode_out);
    chk("rate copied", 2, rate_def_out);
    set_am(1);
    reply();
    ini.field(1);
    wt(9, "loop field on");
    wt(1, "auto receive watch");
    nrt_len_in = 24'h00001e;
    reply();
    wt(2, "no response");
    // Collision during response avoidance keeps own field off
    collision_in = 1;
    ini.field(1);
    wt(9, "field on again");
    ini.field(0);
    wt(8, "field off again");
    seen = 0;
    repeat (40) @(negedge clk_in) seen |= irq_cat_out | field_on_out;
    chk("collision keeps field off", 0, seen);
    collision_in = 0;
    op_control_in = 8'h00;
    submode_in = 0;
    submode_wr_in = 1;
    @(negedge clk_in);
    submode_wr_in = 0;
    repeat (4) @(negedge clk_in);
    chk("back to low power", 1, low_power_out);
    chk("detect mode", 0, submode_out);
    tally_and_finish();
  end
  // Watchdog well beyond the expected run of about three hundred cycles
  initial begin
    #40000;
    num_errors++;
    tally_and_finish();
  end
endmodule // nfc_active_target_sequencer_tb
bind nfc_active_target_sequencer nfc_target_asserts #(.TW(TW), .ARFG_CYCLES(ARFG_CYCLES)) chk_i (.*);
